/* File: design/ees_pkg.sv */
/*
  Shared constants and state encodings of the serial EEPROM target and of
  the bus controller that drives it.
  Assumes a single 125 MHz system clock for both ends.
*/
`default_nettype none
package ees_pkg;
  localparam int CLK_MHZ        = 125;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int ADDR_W         = 12;
  localparam int MEM_BYTES      = 4096;
  localparam int PAGE_W         = 5;
  localparam int PAGE_BYTES     = 32;
  localparam logic [7:0] ERASED = 8'hff;
  // Device type code: the value is arbitrary.
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  // Internal write time in microseconds and its cycle count.
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYC     = WRITE_TIME_US * CLK_MHZ;
  // Controller bus clock period and its quarter in cycles.
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Controller register offsets and fields.
  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_TX   = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_READ_BIT  = 2;
  localparam int CMD_NACK_BIT  = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RX_LSB   = 8;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DEVADR = 6'h02,
    ST_ADRHI  = 6'h04,
    ST_ADRLO  = 6'h08,
    ST_WDATA  = 6'h10,
    ST_RDATA  = 6'h20
  } ees_dev_state_e;

  typedef enum logic [3:0] {
    PH_IDLE  = 4'h1,
    PH_START = 4'h2,
    PH_BITS  = 4'h4,
    PH_STOP  = 4'h8
  } ees_host_phase_e;
endpackage : ees_pkg
`default_nettype wire

/* File: design/ees_i2c_if.sv */
/*
  Two-wire bus between the controller and the EEPROM target.
  Every driver is open drain: a low output with its enable high pulls the
  line, otherwise the pull-up wins. No clocking block; both ends sample.
*/
`default_nettype none
interface ees_i2c_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  assign scl = !(scl_h_oe && !scl_h_o);
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

  modport dev (input scl, sda, output sda_d_o, sda_d_oe);
  modport host (input scl, sda, output scl_h_o, scl_h_oe, sda_h_o,
                sda_h_oe);
endinterface : ees_i2c_if
`default_nettype wire

/* File: design/ees_dev.sv */
/*
  Serial EEPROM target: bus framing, address match, page writes with an
  internal write cycle, write protection and immediate, selective and
  sequential reads over a 4096-byte array.
  Assumes the bus clock comes from the controller and is slow against clk;
  both lines and the strap pins are sampled through two flip-flops.
*/
// Added by the designer: the placing of the registers and strobed register access.
`default_nettype none
module ees_dev #(
  parameter int unsigned WRITE_CYCLES  = ees_pkg::WRITE_CYC,
  parameter logic [3:0]  DEV_TYPE_CODE = ees_pkg::DEV_TYPE_CODE,
  parameter bit          HAS_STRAPS    = 1'b1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  ees_i2c_if.dev    bus,
  input  wire logic chip_select_bit0,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit2,
  input  wire logic write_protect,
  output logic      write_busy
);
  import ees_pkg::*;

  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WRITE_CYCLES - 1);
  localparam logic [TMR_W-1:0] TMR_PAGE = TMR_W'(PAGE_BYTES);

  logic [2:0]        scl_q;
  logic [2:0]        sda_q;
  logic [3:0]        pin_q1;
  logic [3:0]        pin_q2;
  ees_dev_state_e    state_q;
  logic [3:0]        bit_q;
  logic [7:0]        sh_q;
  logic [7:0]        tx_q;
  logic              ack_q;
  logic [ADDR_W-1:0] ptr_q;
  logic              pend_q;
  logic              wp_lat_q;
  logic [PAGE_BYTES-1:0] vld_q;
  logic              busy_q;
  logic [TMR_W-1:0]  tmr_q;
  logic              sda_oe_q;
  logic [7:0]        mem [MEM_BYTES];
  logic [7:0]        page_buf [PAGE_BYTES];

  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic [7:0]        byte_in;
  logic [2:0]        cs;
  logic [PAGE_W-1:0] off;

  // Stage 0 feeds only stage 1; stages 1 and 2 give the edges.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], bus.scl};
      sda_q <= {sda_q[1:0], bus.sda};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q1 <= 4'h0;
      pin_q2 <= 4'h0;
    end else begin
      pin_q1 <= {write_protect, chip_select_bit2, chip_select_bit1,
                 chip_select_bit0};
      pin_q2 <= pin_q1;
    end
  end

  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign byte_in   = {sh_q[6:0], sda_q[1]};
  assign cs        = HAS_STRAPS ? pin_q2[2:0] : 3'h0;
  assign off       = ptr_q[PAGE_W-1:0];

  // Protocol engine. Outside a frame every edge is ignored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ack_q   <= 1'b0;
      ptr_q   <= '0;
      pend_q  <= 1'b0;
      vld_q   <= '0;
    end else if (start_det) begin
      // A restart also drops data that never saw a stop.
      state_q <= ST_DEVADR;
      bit_q   <= 4'h0;
      ack_q   <= 1'b0;
      pend_q  <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      ack_q   <= 1'b0;
      pend_q  <= 1'b0;
    end else if (scl_rise && state_q != ST_IDLE) begin
      if (bit_q != BIT_ACK) begin
        sh_q  <= byte_in;
        bit_q <= bit_q + 4'h1;
        if (bit_q == BIT_LAST) begin
          case (state_q)
            ST_DEVADR: begin
              ack_q <= byte_in[7:4] == DEV_TYPE_CODE &&
                       byte_in[3:1] == cs && !busy_q;
            end
            ST_ADRHI: begin
              ack_q <= 1'b1;
              ptr_q[ADDR_W-1:8] <= byte_in[3:0];
            end
            ST_ADRLO: begin
              ack_q <= 1'b1;
              ptr_q[7:0] <= byte_in;
            end
            ST_WDATA: begin
              if (wp_lat_q) begin
                ack_q <= 1'b0;
              end else begin
                ack_q  <= 1'b1;
                pend_q <= 1'b1;
                vld_q  <= (pend_q ? vld_q : '0) |
                          (PAGE_BYTES'(1) << off);
                ptr_q[PAGE_W-1:0] <= off + PAGE_W'(1);
              end
            end
            default: begin
              ack_q <= 1'b0;
            end
          endcase
        end
      end else begin
        bit_q <= 4'h0;
        case (state_q)
          ST_DEVADR: begin
            if (!ack_q) begin
              state_q <= ST_IDLE;
            end else if (sh_q[0]) begin
              state_q <= ST_RDATA;
              tx_q    <= mem[ptr_q];
              ptr_q   <= ptr_q + ADDR_W'(1);
            end else begin
              state_q <= ST_ADRHI;
            end
          end
          ST_ADRHI: begin
            state_q <= ST_ADRLO;
          end
          ST_ADRLO: begin
            state_q <= ST_WDATA;
          end
          ST_WDATA: begin
            if (!ack_q) begin
              state_q <= ST_IDLE;
            end
          end
          ST_RDATA: begin
            if (sda_q[1]) begin
              state_q <= ST_IDLE;
            end else begin
              tx_q  <= mem[ptr_q];
              ptr_q <= ptr_q + ADDR_W'(1);
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Protection is caught once, on the fall that opens the first data byte.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_lat_q <= 1'b0;
    end else if (scl_fall && state_q == ST_WDATA && bit_q == 4'h0 &&
                 !pend_q) begin
      wp_lat_q <= pin_q2[3];
    end
  end

  always_ff @(posedge clk) begin
    if (scl_rise && state_q == ST_WDATA && bit_q == BIT_LAST &&
        !wp_lat_q) begin
      page_buf[off] <= byte_in;
    end
  end

  // SDA only moves after a fall, so it stays put while SCL is high.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_oe_q <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      if (bit_q == BIT_ACK) begin
        sda_oe_q <= ack_q;
      end else if (state_q == ST_RDATA) begin
        sda_oe_q <= ~tx_q[~bit_q[2:0]];
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
    end else if (busy_q) begin
      tmr_q <= tmr_q + TMR_W'(1);
      if (tmr_q == TMR_LAST) begin
        busy_q <= 1'b0;
      end
    end else if (stop_det && state_q == ST_WDATA && pend_q) begin
      busy_q <= 1'b1;
      tmr_q  <= '0;
    end
  end

  // The commit walks the page one byte a cycle inside the write time, so
  // the array keeps a single write port; WRITE_CYCLES must be at least 32.
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem[i] = ERASED;
    end
  end

  always @(posedge clk) begin
    if (busy_q && tmr_q < TMR_PAGE && vld_q[tmr_q[PAGE_W-1:0]]) begin
      mem[{ptr_q[ADDR_W-1:PAGE_W], tmr_q[PAGE_W-1:0]}] <=
        page_buf[tmr_q[PAGE_W-1:0]];
    end
  end

  assign bus.sda_d_oe = sda_oe_q;
  assign bus.sda_d_o  = 1'b0;
  assign write_busy   = busy_q;
endmodule : ees_dev
`default_nettype wire

/* File: design/ees_host.sv */
/*
  Bus controller: runs one byte transfer per command, with optional start
  before and stop after, and reports acknowledge and received data.
  Assumes software sequences the bytes of each command through a plain
  register port and polls the busy bit.
*/
`default_nettype none
module ees_host #(
  parameter int unsigned QTR_CYCLES = ees_pkg::SCL_QTR_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  ees_i2c_if.host          bus,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  import ees_pkg::*;

  localparam int Q_W = $clog2(QTR_CYCLES + 1);
  localparam logic [Q_W-1:0] Q_LAST = Q_W'(QTR_CYCLES - 1);

  logic [1:0]      sda_q;
  ees_host_phase_e phase_q;
  logic [5:0]      step_q;
  logic [Q_W-1:0]  qcnt_q;
  logic [3:0]      cmd_q;
  logic [7:0]      tx_q;
  logic [7:0]      rx_q;
  logic            nack_q;
  logic            scl_low_q;
  logic            sda_low_q;
  logic [31:0]     rdata_q;
  logic            tick;
  logic [3:0]      bnum;
  logic            idle;

  assign tick = qcnt_q == Q_LAST;
  assign bnum = step_q[5:2];
  assign idle = phase_q == PH_IDLE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_q <= 2'h3;
    end else begin
      sda_q <= {sda_q[0], bus.sda};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qcnt_q <= '0;
    end else if (idle || tick) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + Q_W'(1);
    end
  end

  // Commands written while a transfer runs are dropped.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= 8'h00;
    end else if (reg_wr && idle && reg_addr == REG_TX) begin
      tx_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q   <= PH_IDLE;
      step_q    <= 6'h00;
      cmd_q     <= 4'h0;
      rx_q      <= 8'h00;
      nack_q    <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (idle) begin
      if (reg_wr && reg_addr == REG_CMD) begin
        cmd_q   <= reg_wdata[3:0];
        nack_q  <= 1'b0;
        step_q  <= 6'h00;
        phase_q <= reg_wdata[CMD_START_BIT] ? PH_START : PH_BITS;
      end
    end else if (tick) begin
      step_q <= step_q + 6'h01;
      case (phase_q)
        PH_START: begin
          case (step_q[1:0])
            2'h0: sda_low_q <= 1'b0;
            2'h1: scl_low_q <= 1'b0;
            2'h2: sda_low_q <= 1'b1;
            default: begin
              scl_low_q <= 1'b1;
              step_q    <= 6'h00;
              phase_q   <= PH_BITS;
            end
          endcase
        end
        PH_BITS: begin
          case (step_q[1:0])
            2'h0: begin
              if (bnum == BIT_ACK) begin
                sda_low_q <= cmd_q[CMD_READ_BIT] &
                             ~cmd_q[CMD_NACK_BIT];
              end else begin
                sda_low_q <= ~cmd_q[CMD_READ_BIT] &
                             ~tx_q[~bnum[2:0]];
              end
            end
            2'h1: scl_low_q <= 1'b0;
            2'h2: begin
              if (bnum != BIT_ACK) begin
                rx_q <= {rx_q[6:0], sda_q[1]};
              end else if (!cmd_q[CMD_READ_BIT]) begin
                nack_q <= sda_q[1];
              end
            end
            default: begin
              scl_low_q <= 1'b1;
              if (bnum == BIT_ACK) begin
                step_q <= 6'h00;
                sda_low_q <= cmd_q[CMD_STOP_BIT];
                phase_q <= cmd_q[CMD_STOP_BIT] ? PH_STOP : PH_IDLE;
              end
            end
          endcase
        end
        PH_STOP: begin
          case (step_q[1:0])
            2'h0: sda_low_q <= 1'b1;
            2'h1: scl_low_q <= 1'b0;
            2'h2: sda_low_q <= 1'b0;
            default: phase_q <= PH_IDLE;
          endcase
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else if (reg_rd && reg_addr == REG_STAT) begin
      rdata_q <= 32'h0;
      rdata_q[STAT_RX_LSB +: 8] <= rx_q;
      rdata_q[STAT_NACK_BIT]    <= nack_q;
      rdata_q[STAT_BUSY_BIT]    <= !idle;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign bus.scl_h_o  = 1'b0;
  assign bus.scl_h_oe = scl_low_q;
  assign bus.sda_h_o  = 1'b0;
  assign bus.sda_h_oe = sda_low_q;
  assign reg_rdata    = rdata_q;
endmodule : ees_host
`default_nettype wire

/* File: dv/ees_bus_props.sv */
/*
  Checker for the two-wire link between controller and target.
  Assumes both lines change slowly against clk.
*/
`default_nettype none
module ees_bus_props #(
  parameter int unsigned WRITE_CYCLES  = 2000,
  parameter logic [3:0]  DEV_TYPE_CODE = 4'h5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        scl_q;
  logic        sda_q;
  logic        first_q;
  logic        seen_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic [3:0]  since_q;
  logic [31:0] busy_q;
  wire         start_ev = scl && scl_q && !sda && sda_q;
  wire         stop_ev  = scl && scl_q && sda && !sda_q;
  wire         rise_ev  = scl && !scl_q;

  // Byte slot tracking restarts at every start, repeated or not.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      since_q <= 4'hf;
      busy_q <= 32'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      first_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      since_q <= stop_ev ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
      busy_q <= write_busy ? busy_q + 32'h1 : 32'h0;
      if (start_ev) begin
        bit_q <= 4'h0;
        first_q <= 1'b1;
        seen_q <= 1'b1;
      end else if (rise_ev) begin
        sh_q <= {sh_q[6:0], sda};
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        first_q <= first_q && bit_q != 4'h8;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_drive_low;
    $rose(sda_d_oe) |-> !scl && !$past(scl);
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("target drove data while clock high");
  property p_dev_stable;
    scl && scl_q |-> $stable(sda_d_oe);
  endproperty
  a_dev_stable: assert property (p_dev_stable)
    else $error("target data moved while clock high");
  property p_host_edge;
    scl && scl_q && $changed(sda_h_oe) |-> start_ev || stop_ev;
  endproperty
  a_host_edge: assert property (p_host_edge)
    else $error("controller data moved outside start or stop");
  property p_quiet;
    sda_d_oe |-> seen_q;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("target drove before any start");
  property p_match;
    rise_ev && first_q && bit_q == 4'h8 && sda_d_oe |-> sh_q[7:1] ==
      {DEV_TYPE_CODE, chip_select_bit2, chip_select_bit1, chip_select_bit0};
  endproperty
  a_match: assert property (p_match)
    else $error("target acknowledged a foreign address");
  property p_ninth;
    rise_ev && bit_q == 4'h8 |-> !(sda_h_oe && sda_d_oe);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("both ends drove on the acknowledge clock");
  property p_busy_quiet;
    write_busy |-> !sda_d_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("target drove during internal write");
  property p_busy_start;
    $rose(write_busy) |-> since_q < 4'hc;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("internal write began without a stop");
  property p_busy_len;
    $fell(write_busy) |-> busy_q >= WRITE_CYCLES - 1 &&
      busy_q <= WRITE_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("internal write length wrong");
endmodule : ees_bus_props
`default_nettype wire

/* File: dv/ees_bench.sv */
/*
  Self-checking bench: controller registers drive the target over the
  shared interface while a byte array mirrors the memory.
  Assumes a shortened internal write time.
*/
`default_nettype none
module ees_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ees_pkg::*;
  localparam int WCYC = 2000;
  localparam logic [31:0] CS = 32'h1;
  localparam logic [31:0] CP = 32'h2;
  localparam logic [31:0] CR = 32'h4;
  localparam logic [31:0] CN = 32'h8;
  logic        clk;
  logic        sys_rst;
  logic [2:0]  cs;
  logic        wp;
  logic        busy;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  mdl [MEM_BYTES];
  logic [11:0] ptr;
  logic [11:0] a;
  int          seed;
  int          n;
  int          err_total;
  int          num_checks;

  ees_i2c_if bus ();
  ees_dev #(.WRITE_CYCLES(WCYC)) i_ees_dev (.clk(clk), .sys_rst(sys_rst),
    .bus(bus), .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
    .chip_select_bit2(cs[2]), .write_protect(wp), .write_busy(busy));
  ees_host #(.QTR_CYCLES(8)) i_ees_host (.clk(clk), .sys_rst(sys_rst),
    .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ees_bus_props #(.WRITE_CYCLES(WCYC), .DEV_TYPE_CODE(DEV_TYPE_CODE))
    chk_props (.clk(clk), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda),
    .sda_h_oe(bus.sda_h_oe), .sda_d_oe(bus.sda_d_oe),
    .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
    .chip_select_bit2(cs[2]), .write_busy(busy));

  always #4 clk = ~clk;

  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic rw(logic [3:0] ad, logic [31:0] d, bit rd,
                    output logic [31:0] q);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= !rd;
    reg_rd <= rd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Read data stand for the cycle after the strobe; taking them at the
    // closing edge also leaves a full edge between two strobes.
    @(posedge clk);
    q = reg_rdata;
  endtask : rw

  // One byte slot; busy is polled with a bound so a hang ends the run.
  task automatic xfer(logic [31:0] cmd, logic [7:0] tx, output logic nk,
                      output logic [7:0] rx);
    logic [31:0] q;
    int          k;
    rw(REG_TX, {24'h0, tx}, 1'b0, q);
    rw(REG_CMD, cmd, 1'b0, q);
    k = 0;
    do begin
      rw(REG_STAT, 32'h0, 1'b1, q);
      k++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && k < 2000);
    if (q[STAT_BUSY_BIT] !== 1'b0) begin
      err_total++;
      give_verdict();
    end
    nk = q[STAT_NACK_BIT];
    rx = q[STAT_RX_LSB+:8];
  endtask : xfer

  function automatic logic [7:0] dadr(bit r);
    return {DEV_TYPE_CODE, cs, r};
  endfunction : dadr

  task automatic wr_seq(logic [11:0] ad, int cnt, bit fin);
    logic       nk;
    logic [7:0] rx;
    logic [7:0] b;
    xfer(CS, dadr(0), nk, rx);
    chk("ack_adr", nk, 0);
    xfer(0, {4'h0, ad[11:8]}, nk, rx);
    chk("ack_hi", nk, 0);
    xfer(0, ad[7:0], nk, rx);
    chk("ack_lo", nk, 0);
    for (int i = 0; i < cnt; i++) begin
      b = 8'($random(seed));
      xfer((i == cnt - 1 && fin) ? CP : 0, b, nk, rx);
      chk("ack_dat", nk, {11'h0, wp && i == 0});
      if (fin && !wp) mdl[{ad[11:5], ad[4:0] + 5'(i)}] = b;
    end
  endtask : wr_seq

  task automatic rd_seq(bit sel, logic [11:0] ad, int cnt);
    logic       nk;
    logic [7:0] rx;
    if (sel) begin
      xfer(CS, dadr(0), nk, rx);
      xfer(0, {4'($random(seed)), ad[11:8]}, nk, rx);
      xfer(0, ad[7:0], nk, rx);
      chk("ack_sel", nk, 0);
      ptr = ad;
    end
    xfer(CS, dadr(1), nk, rx);
    chk("ack_rd", nk, 0);
    for (int i = 0; i < cnt; i++) begin
      xfer(CR | ((i == cnt - 1) ? (CN | CP) : 0), 8'h0, nk, rx);
      chk("rd_dat", {4'h0, rx}, {4'h0, mdl[ptr]});
      ptr++;
    end
  endtask : rd_seq

  task automatic poll(output int cnt);
    logic       nk;
    logic [7:0] rx;
    cnt = 0;
    do begin
      xfer(CS | CP, dadr(0), nk, rx);
      cnt++;
    end while (nk !== 1'b0 && cnt < 100);
    chk("poll_ack", nk, 0);
    if (nk !== 1'b0) begin
      give_verdict();
    end
  endtask : poll

  initial begin
    logic       nk;
    logic [7:0] rx;
    clk = 1'b0;
    sys_rst = 1'b1;
    seed = 32'h2d75;
    cs = 3'($random(seed));
    wp = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    num_checks = 0;
    foreach (mdl[i]) mdl[i] = ERASED;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_seq(1, 12'($random(seed)), 2);
    rd_seq(0, 12'h0, 1);
    $display("test erased done");
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 12'hfff : 12'($random(seed));
      wr_seq(a, 1, 1);
      poll(n);
      chk("poll_nack", 12'(n > 1), 1);
      rd_seq(1, a, 1);
    end
    $display("test byte write done");
    a = {7'($random(seed)), 5'h1e};
    wr_seq(a, 34, 1);
    poll(n);
    rd_seq(1, {a[11:5], 5'h0}, 32);
    $display("test page write done");
    wp <= 1'b1;
    wr_seq(a, 1, 1);
    poll(n);
    chk("wp_no_busy", 12'(n), 1);
    wp <= 1'b0;
    wr_seq(a, 2, 0);
    poll(n);
    chk("abort_no_busy", 12'(n), 1);
    rd_seq(1, a, 2);
    $display("test refused writes done");
    for (int b = 1; b < 8; b++) begin
      xfer(CS | CP, dadr(0) ^ (8'h1 << b), nk, rx);
      chk("foreign_adr", nk, 1);
    end
    rd_seq(1, 12'hffe, 4);
    $display("test address and wrap done");
    give_verdict();
  end
endmodule : ees_bench
`default_nettype wire
